// [src/brs_pkg.sv]
/*
 * Shared constants and types for the boot reset sequencer: cycle counts,
 * coprocessor instruction memory layout, boot image and boot rom range.
 * Assumes a single 40 MHz device clock; no software-visible registers.
 */
package brs_pkg;

    // =====================================================================
    // timing
    // =====================================================================
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned POR_CYCLES_DEF = 6192;
    localparam int unsigned POR_CW = 13;
    // ack wait bound; a healthy copy finishes far sooner than this
    localparam int unsigned ACK_TIMEOUT = 1024;
    localparam int unsigned ACK_CW = 11;

    // =====================================================================
    // coprocessor instruction memory
    // =====================================================================
    localparam int unsigned IMEM_AW = 4;
    localparam int unsigned IMEM_DEPTH = 16;
    localparam int unsigned IMEM_DW = 32;
    localparam logic [IMEM_AW-1:0] PAD_COUNT = 4'h4;
    localparam logic [IMEM_AW-1:0] IMG_LAST = 4'h7;
    localparam logic [IMEM_DW-1:0] NOP_OPCODE = 32'h12E0E0E0;

    // =====================================================================
    // boot rom address range used by the stall loop
    // =====================================================================
    localparam logic [31:0] ROM_BASE = 32'h00700000;
    localparam logic [31:0] ROM_LAST = 32'h007FFFFC;
    localparam logic [31:0] PC_STEP = 32'h00000004;

    // =====================================================================
    // reset values
    // =====================================================================
    localparam logic RST_INDICATOR = 1'b0;
    localparam logic [POR_CW-1:0] RST_POR_CNT = 13'h0000;

    typedef struct packed {
        logic rst_n;  // coprocessor held in reset while low
        logic run;    // coprocessor fetch enable
    } brs_cop_ctrl_t;

    localparam brs_cop_ctrl_t COP_HELD = '{rst_n: 1'b0, run: 1'b0};
    localparam brs_cop_ctrl_t COP_GO = '{rst_n: 1'b1, run: 1'b1};

    typedef enum logic [2:0] {
        ST_POR,
        ST_WRITE,
        ST_VRD,
        ST_VCMP,
        ST_KICK,
        ST_WAIT,
        ST_DONE,
        ST_FAIL
    } brs_state_t;

    // image: harmless pad opcodes first, then the vector-table copy program
    function automatic logic [IMEM_DW-1:0] img_word(
        input logic [IMEM_AW-1:0] idx
    );
        logic [IMEM_DW-1:0] w;
        w = NOP_OPCODE;
        case (idx)
            4'h4: w = 32'h240000E1;
            4'h5: w = 32'h24FFFFE2;
            4'h6: w = 32'hE1002081;
            4'h7: w = 32'h2A000000;
            default: w = NOP_OPCODE;
        endcase
        return w;
    endfunction

endpackage

// [src/brs_imem.sv]
/*
 * Coprocessor instruction memory: single port, synchronous write,
 * read data held in a register one cycle after the address.
 * Assumes the caller arbitrates between loader and coprocessor fetch.
 */
`timescale 1ns/1ps
module brs_imem
    import brs_pkg::*;
(
    input wire logic clk,                    // device clock
    input wire logic we,                     // write strobe
    input wire logic [IMEM_AW-1:0] addr,     // word address
    input wire logic [IMEM_DW-1:0] wdata,    // write data
    output logic [IMEM_DW-1:0] rdata_q       // registered read data
);

    // =====================================================================
    // storage
    // =====================================================================
    // no reset on purpose: contents and read bus are random at power-up
    logic [IMEM_DW-1:0] mem [IMEM_DEPTH];
    logic [IMEM_DW-1:0] rdata_d;

    always_comb
    begin
        rdata_d = mem[addr];
    end

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata_q <= rdata_d;
    end

endmodule // brs_imem

// [src/brs_sequencer.sv]
/*
 * Boot reset sequencer: power-on count, reset output indicator, loading
 * and verification of the coprocessor instruction memory, coprocessor
 * start and acknowledgement wait, boot rom stall loop on failure.
 * Assumes rstn comes from the board reset source and cop_ack from
 * coprocessor logic on the same clock.
 */
`timescale 1ns/1ps
module brs_sequencer
    import brs_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_CYCLES_DEF
)
(
    input wire logic clk,                          // 40 MHz device clock
    input wire logic rstn,                         // board reset, low active
    input wire logic cop_ack,                      // copy done from coprocessor
    input wire logic [IMEM_AW-1:0] cop_fetch_addr, // coprocessor fetch address
    output logic [IMEM_DW-1:0] cop_fetch_data,     // fetched instruction
    output brs_cop_ctrl_t cop_ctrl_q,              // coprocessor reset/enable
    output logic reset_output_indicator_q,         // reset-out pin level
    output logic boot_busy_q,                      // boot sequence running
    output logic boot_done_q,                      // handoff to user boot
    output logic boot_fail_q,                      // stuck in rom loop
    output logic [31:0] rom_pc_q                   // boot rom loop address
);

    // =====================================================================
    // reset synchroniser
    // =====================================================================
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // =====================================================================
    // sequencer state
    // =====================================================================
    localparam logic [POR_CW-1:0] POR_LAST = POR_CW'(POR_CYCLES - 1);
    localparam logic [ACK_CW-1:0] ACK_LAST = ACK_CW'(ACK_TIMEOUT - 1);

    brs_state_t state_q, state_d;
    logic [POR_CW-1:0] por_cnt_q, por_cnt_d;
    logic [ACK_CW-1:0] ack_cnt_q, ack_cnt_d;
    logic [IMEM_AW-1:0] idx_q, idx_d;
    brs_cop_ctrl_t cop_ctrl_d;
    logic ind_d;
    logic busy_d;
    logic done_d;
    logic fail_d;
    logic [31:0] pc_d;

    logic mem_we;
    logic [IMEM_AW-1:0] mem_addr;
    logic [IMEM_DW-1:0] mem_rdata;

    always_comb
    begin
        state_d = state_q;
        por_cnt_d = por_cnt_q;
        ack_cnt_d = ack_cnt_q;
        idx_d = idx_q;
        cop_ctrl_d = cop_ctrl_q;
        ind_d = reset_output_indicator_q;
        busy_d = boot_busy_q;
        done_d = boot_done_q;
        fail_d = boot_fail_q;
        pc_d = rom_pc_q;
        mem_we = 1'b0;
        mem_addr = idx_q;
        case (state_q)
            ST_POR:
            begin
                por_cnt_d = por_cnt_q + POR_CW'(1);
                if (por_cnt_q == POR_LAST)
                begin
                    ind_d = ~RST_INDICATOR;
                    busy_d = 1'b1;
                    idx_d = '0;
                    state_d = ST_WRITE;
                end
            end
            ST_WRITE:
            begin
                mem_we = 1'b1;
                idx_d = idx_q + IMEM_AW'(1);
                if (idx_q == IMG_LAST)
                begin
                    idx_d = '0;
                    state_d = ST_VRD;
                end
            end
            ST_VRD:
            begin
                state_d = ST_VCMP;
            end
            ST_VCMP:
            begin
                if (mem_rdata != img_word(idx_q))
                begin
                    busy_d = 1'b0;
                    fail_d = 1'b1;
                    state_d = ST_FAIL;
                end
                else if (idx_q == IMG_LAST)
                begin
                    state_d = ST_KICK;
                end
                else
                begin
                    idx_d = idx_q + IMEM_AW'(1);
                    state_d = ST_VRD;
                end
            end
            ST_KICK:
            begin
                // release and enable in one write
                cop_ctrl_d = COP_GO;
                ack_cnt_d = '0;
                state_d = ST_WAIT;
            end
            ST_WAIT:
            begin
                ack_cnt_d = ack_cnt_q + ACK_CW'(1);
                if (cop_ack)
                begin
                    busy_d = 1'b0;
                    done_d = 1'b1;
                    state_d = ST_DONE;
                end
                else if (ack_cnt_q == ACK_LAST)
                begin
                    busy_d = 1'b0;
                    fail_d = 1'b1;
                    state_d = ST_FAIL;
                end
            end
            ST_DONE:
            begin
                state_d = ST_DONE;
            end
            ST_FAIL:
            begin
                if (rom_pc_q >= ROM_LAST)
                begin
                    pc_d = ROM_BASE;
                end
                else
                begin
                    pc_d = rom_pc_q + PC_STEP;
                end
            end
            default:
            begin
                state_d = ST_POR;
            end
        endcase
        if (cop_ctrl_q.run)
        begin
            mem_addr = cop_fetch_addr;
        end
    end

    // every reset reloads and verifies image
    // any later reset reruns full boot
    always_ff @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            state_q <= ST_POR;
            por_cnt_q <= RST_POR_CNT;
            ack_cnt_q <= '0;
            idx_q <= '0;
            cop_ctrl_q <= COP_HELD;
            reset_output_indicator_q <= RST_INDICATOR;
            boot_busy_q <= 1'b0;
            boot_done_q <= 1'b0;
            boot_fail_q <= 1'b0;
            rom_pc_q <= ROM_BASE;
        end
        else
        begin
            state_q <= state_d;
            por_cnt_q <= por_cnt_d;
            ack_cnt_q <= ack_cnt_d;
            idx_q <= idx_d;
            cop_ctrl_q <= cop_ctrl_d;
            reset_output_indicator_q <= ind_d;
            boot_busy_q <= busy_d;
            boot_done_q <= done_d;
            boot_fail_q <= fail_d;
            rom_pc_q <= pc_d;
        end
    end

    // =====================================================================
    // coprocessor instruction memory
    // =====================================================================
    // fetch data is the memory's own output register
    brs_imem u_imem (
        .clk(clk),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(img_word(idx_q)),
        .rdata_q(mem_rdata)
    );

    assign cop_fetch_data = mem_rdata;

endmodule // brs_sequencer

// [tb/brs_sequencer_properties.sv]
/* Checker for brs_sequencer: indicator timing, coprocessor start, ack
   handling and rom loop. Assumes it is bound onto the sequencer top. */
`timescale 1ns/1ps
module brs_sequencer_properties
    import brs_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_CYCLES_DEF
)
(
    input wire logic clk,                      // device clock
    input wire logic rstn,                     // board reset
    input wire logic cop_ack,                  // copy done
    input wire brs_cop_ctrl_t cop_ctrl_q,      // coprocessor control
    input wire logic reset_output_indicator_q, // reset out level
    input wire logic boot_busy_q,              // boot running
    input wire logic boot_done_q,              // boot done
    input wire logic boot_fail_q,              // boot failed
    input wire logic [31:0] rom_pc_q           // rom loop address
);
    // ==========
    // helper count
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    // counts edges from release; includes the two sync edges
    always_comb
    begin
        cnt_d = cnt_q;
        if (!reset_output_indicator_q) cnt_d = cnt_q + 16'h0001;
    end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn) cnt_q <= 16'h0000;
        else cnt_q <= cnt_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ==========
    // properties
    AST_POR_COUNT: assert property ($rose(reset_output_indicator_q) |->
        cnt_q == 16'(POR_CYCLES + 2)) else $error("indicator late or early");
    AST_IND_HOLD: assert property (reset_output_indicator_q |=>
        reset_output_indicator_q) else $error("indicator dropped");
    AST_VERIFY_FIRST: assert property ($rose(reset_output_indicator_q) |->
        (cop_ctrl_q == COP_HELD)[*8] ##1 (cop_ctrl_q == COP_HELD)[*8])
        else $error("coprocessor released before verify");
    AST_KICK_TIME: assert property ($rose(reset_output_indicator_q) |->
        ##[20:30] cop_ctrl_q == COP_GO) else $error("coprocessor not started");
    AST_ONE_WRITE: assert property (cop_ctrl_q == COP_HELD ||
        cop_ctrl_q == COP_GO) else $error("partial coprocessor control");
    AST_GO_HOLDS: assert property (cop_ctrl_q == COP_GO |=>
        cop_ctrl_q == COP_GO) else $error("coprocessor stopped");
    AST_DONE_ACK: assert property ($rose(boot_done_q) |-> $past(cop_ack) &&
        $past(cop_ctrl_q) == COP_GO && !boot_busy_q) else $error("bad done");
    AST_ONE_END: assert property (boot_busy_q |->
        !boot_done_q && !boot_fail_q) else $error("busy after end");
    AST_PC_HOME: assert property (!boot_fail_q |-> rom_pc_q == ROM_BASE)
        else $error("rom pc moved without fail");
    AST_FAIL_LOOP: assert property (boot_fail_q && $past(boot_fail_q) |->
        rom_pc_q == (($past(rom_pc_q) == ROM_LAST) ? ROM_BASE :
        $past(rom_pc_q) + PC_STEP)) else $error("rom loop step wrong");
endmodule // brs_sequencer_properties

bind brs_sequencer brs_sequencer_properties #(.POR_CYCLES(POR_CYCLES)) u_props
    (.clk(clk), .rstn(rstn), .cop_ack(cop_ack), .cop_ctrl_q(cop_ctrl_q),
     .reset_output_indicator_q(reset_output_indicator_q),
     .boot_busy_q(boot_busy_q), .boot_done_q(boot_done_q),
     .boot_fail_q(boot_fail_q), .rom_pc_q(rom_pc_q));

// [tb/brs_reset_source.sv]
/* Board reset source model: first reset, then an optional single
   secondary pulse after a long high time. Assumes start is one cycle. */
`timescale 1ns/1ps
module brs_reset_source
#(
    parameter int HI_CYC = 300,
    parameter int LO_CYC = 2
)
(
    input wire logic clk,      // device clock
    input wire logic start,    // begin a power-on sequence
    input wire logic with_sec, // add the secondary pulse
    output logic rstn          // board reset to the device
);
    // ==========
    // sequence
    initial rstn = 1'b0;
    // one low pulse, then optional timed high and a second low pulse
    // start is set on a falling edge, so take it on the rising one
    always @(posedge clk)
    begin
        if (start)
        begin
            @(negedge clk);
            rstn <= 1'b0;
            repeat (LO_CYC) @(negedge clk);
            rstn <= 1'b1;
            if (with_sec) begin
                repeat (HI_CYC) @(negedge clk);
                rstn <= 1'b0;
                repeat (LO_CYC) @(negedge clk);
                rstn <= 1'b1;
            end
        end
    end
endmodule // brs_reset_source

// [tb/brs_sequencer_tb.sv]
/* Testbench for brs_sequencer: boots with and without ack, secondary
   reset, fetch readback. Assumes the reset source model drives rstn. */
`timescale 1ns/1ps
module brs_sequencer_tb
    import brs_pkg::*;
;
    localparam int unsigned POR = 16;
    logic clk, rstn, cop_ack, start, with_sec, ind, busy, done, fail;
    logic [IMEM_AW-1:0] addr;
    logic [IMEM_DW-1:0] fdata;
    logic [IMEM_DW-1:0] exp_q[$];
    logic [31:0] pc;
    brs_cop_ctrl_t ctrl;
    int miscompares = 0;
    int total_checks = 0;
    int seed = 32'hf54c;
    brs_sequencer #(.POR_CYCLES(POR)) uut (.clk(clk), .rstn(rstn),
        .cop_ack(cop_ack), .cop_fetch_addr(addr), .cop_fetch_data(fdata),
        .cop_ctrl_q(ctrl), .reset_output_indicator_q(ind),
        .boot_busy_q(busy), .boot_done_q(done), .boot_fail_q(fail),
        .rom_pc_q(pc));
    brs_reset_source u_src (.clk(clk), .start(start), .with_sec(with_sec),
        .rstn(rstn));
    // ==========
    // helpers
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] img(input logic [3:0] i);
        case (i)
            4'h4: return 32'h240000E1;
            4'h5: return 32'h24FFFFE2;
            4'h6: return 32'hE1002081;
            4'h7: return 32'h2A000000;
            default: return NOP_OPCODE;
        endcase
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wait_rst(input logic lvl);
        int n;
        n = 0;
        while (rstn !== lvl && n < 400) begin
            @(negedge clk);
            n++;
        end
        check(32'(n < 400), 32'h1);
    endtask
    // one boot: early ack refused, fetch the eight image words, then ack or timeout
    task automatic boot(input logic trig, input logic sec, input logic ack);
        int n;
        logic [3:0] r;
        if (trig) begin
            with_sec = sec;
            start = 1'b1;
            @(negedge clk);
            start = 1'b0;
        end
        wait_rst(1'b0);
        wait_rst(1'b1);
        check(ind, 1'b0);
        cop_ack = 1'b1;
        repeat (POR) @(negedge clk);
        cop_ack = 1'b0;
        n = 0;
        while (ctrl !== COP_GO && n < 60) begin
            @(negedge clk);
            n++;
        end
        check(32'(n < 60), 32'h1);
        check(done, 1'b0);
        check(busy, 1'b1);
        check(ind, 1'b1);
        r = 4'($random(seed));
        // only the eight image words are loaded; the rest stays unwritten
        for (int i = 0; i < 16; i++)
        begin
            addr = {1'b0, 3'(i) ^ r[2:0]};
            exp_q.push_back(img(addr));
            @(negedge clk);
        end
        @(negedge clk);
        if (ack) begin
            repeat (3'($random(seed))) @(negedge clk);
            cop_ack = 1'b1;
            @(negedge clk);
            cop_ack = 1'b0;
        end
        n = 0;
        while (done !== 1'b1 && fail !== 1'b1 && n < 1100) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        check(done, ack);
        check(fail, !ack);
        check(busy, 1'b0);
        repeat (5) @(negedge clk);
        check(32'(pc[31:20] == 12'h007 && pc[1:0] == 2'h0), 32'h1);
        $display("boot test done ack=%0d", ack);
    endtask
    // ==========
    // scoreboard and run
    always @(posedge clk)
    begin
        if (exp_q.size() > 0) begin
            #1;
            check(fdata, exp_q.pop_front());
        end
    end
    initial
    begin
        #150000;
        miscompares++;
        final_report();
    end
    initial
    begin
        cop_ack = 1'b0;
        addr = 4'h0;
        start = 1'b0;
        with_sec = 1'b0;
        @(negedge clk);
        boot(1'b1, 1'b1, 1'b1);
        boot(1'b0, 1'b0, 1'b1);
        boot(1'b1, 1'b0, 1'b0);
        // a source reset after the failed boot must recover
        boot(1'b1, 1'b0, 1'b1);
        final_report();
    end
endmodule // brs_sequencer_tb
